// [break_trace_pkg.sv]
package break_trace_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SRC_TRACE = 8'h08;
  localparam logic [7:0] OFS_DST_TRACE = 8'h0C;
  localparam logic [7:0] OFS_SPACE_ID = 8'h10;

  // Control register field positions
  localparam int unsigned BIT_ID_MASK_A = 21;
  localparam int unsigned BIT_FLAG_CPU_A = 15;
  localparam int unsigned BIT_FLAG_CPU_B = 14;
  localparam int unsigned BIT_FLAG_DMA_A = 13;
  localparam int unsigned BIT_FLAG_DMA_B = 12;
  localparam int unsigned BIT_TRACE_EN = 11;
  localparam int unsigned BIT_AFTER_A = 10;
  localparam int unsigned BIT_DATA_EN_B = 7;
  localparam int unsigned BIT_AFTER_B = 6;
  localparam int unsigned BIT_SEQ = 3;
  localparam int unsigned BIT_COUNT_EN = 0;

  // Writable control bits; all else reads 0
  localparam logic [31:0] CTRL_RW_MASK = 32'h0030_FCC9;
  // Match flags: cleared by writing 0
  localparam logic [31:0] CTRL_FLAG_MASK = 32'h0000_F000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Trace entry layout
  localparam int unsigned TRACE_VALID_BIT = 31;
  localparam int unsigned ADDR_W = 28;
  localparam int unsigned PTR_W = 3;

  // Count register
  localparam int unsigned COUNT_W = 12;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [11:0] COUNT_LAST = 12'h001;

  // Odd decode pointer names buffer pointer plus two
  localparam logic [3:0] PTR_ODD_OFFSET = 4'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : break_trace_pkg

// [break_control_branch_trace.sv]
`timescale 1ns/10ps
// How it works
// - Control bit 12 shows the channel B DMAC match; resets to 0.
// - Control bit 11 enables branch trace capture; reset disables it.
// - Bit 10 picks channel A fetch break before (0) or after (1).
// - Reserved control bits read 0; software writes 0 there.
// - Bit 7 adds the data comparison to channel B's condition.
// - Bit 6 picks channel B fetch break before (0) or after (1).
// - Bit 3 makes A then B sequential; 0 keeps channels independent.
// - Bit 0 enables the channel B execution-count break; reset masks it.
// - Count register holds 12 writable bits; upper bits read 0.
// - Power-on reset clears the count register to zero.
// - Each channel B match decrements a nonzero count while counting is on; in sequential mode only B after A counts.
// - Count break fires on a channel B match while count holds one.
// - Source entry holds last fetch address and 3-bit decode pointer.
// - Even pointer names the buffer; odd names pointer plus two.
// - Source valid bit sets on capture, clears when software reads it.
// - Resets clear both valid flags; trace data survives every reset.
// - Both traces are eight-entry queues shifting on every branch while bit 11 is set.
// - Destination entry holds first fetch after branch; 30..28 read 0.
// - Destination valid sets on capture, clears on read of it.
// - Eight-bit channel A space id register, never reset.
// - Id mask bit set skips the channel A space id comparison.
// - Match flags set by hardware, cleared by writing 0 or by power-on reset.
module break_control_branch_trace #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AXI_ADDR_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic manual_reset_i,
  // Qualified comparator hits from the bus watchers
  input wire logic cpu_match_a_i,
  input wire logic dmac_match_a_i,
  input wire logic cpu_match_b_i,
  input wire logic dmac_match_b_i,
  input wire logic data_match_b_i,
  input wire logic [7:0] address_space_id_i,
  input wire logic fetch_a_i,
  input wire logic fetch_b_i,
  input wire logic exec_done_i,
  // Branch capture from the core
  input wire logic branch_i,
  input wire logic [27:0] source_addr_i,
  input wire logic [2:0] decode_buffer_ptr_i,
  input wire logic [27:0] dest_addr_i,
  // Break requests out
  output logic break_req_o,
  output logic break_post_o,
  output logic break_chan_b_o,
  output logic [3:0] source_buffer_num_o,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [11:0] count;
    logic [7:0] space_id;
    logic [DEPTH-1:0] src_valid;
    logic [DEPTH-1:0][30:0] src_entry;
    logic [DEPTH-1:0] dst_valid;
    logic [DEPTH-1:0][27:0] dst_addr;
    logic seq_armed;
    logic pend_a;
    logic pend_b;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic brk_req;
    logic brk_post;
    logic brk_chan_b;
    logic [3:0] buf_num;
  } state_t;
  state_t q;
  state_t d;

  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Word address compare, low two bits ignored
  function automatic logic hit(input logic [AXI_ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a[AXI_ADDR_W-1:2] == ofs[AXI_ADDR_W-1:2]);
  endfunction : hit

  // Byte lanes to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    lanes = m;
  endfunction : lanes

  // Pointer to instruction buffer number
  function automatic logic [3:0] buf_of(input logic [2:0] p);
    buf_of = p[0] ? {1'b0, p} + break_trace_pkg::PTR_ODD_OFFSET
                  : {1'b0, p};
  endfunction : buf_of

  ////////////////////////////////////////////////////////////////////
  // Decoded control bits and match conditions
  logic trace_en;
  logic after_a;
  logic after_b;
  logic data_en_b;
  logic seq_mode;
  logic count_en;
  logic id_ok_a;
  logic hit_cpu_a;
  logic hit_dma_a;
  logic hit_a;
  logic hit_cpu_b;
  logic hit_dma_b;
  logic hit_b;

  assign trace_en = q.ctrl[break_trace_pkg::BIT_TRACE_EN];
  assign after_a = q.ctrl[break_trace_pkg::BIT_AFTER_A];
  assign after_b = q.ctrl[break_trace_pkg::BIT_AFTER_B];
  assign data_en_b = q.ctrl[break_trace_pkg::BIT_DATA_EN_B];
  assign seq_mode = q.ctrl[break_trace_pkg::BIT_SEQ];
  assign count_en = q.ctrl[break_trace_pkg::BIT_COUNT_EN];

  // Channel A: space id check unless masked
  assign id_ok_a = q.ctrl[break_trace_pkg::BIT_ID_MASK_A] ||
                   (address_space_id_i == q.space_id);
  assign hit_cpu_a = cpu_match_a_i && id_ok_a;
  assign hit_dma_a = dmac_match_a_i && id_ok_a;
  assign hit_a = hit_cpu_a || hit_dma_a;

  // Channel B: data compare only when enabled
  assign hit_cpu_b = cpu_match_b_i && (!data_en_b || data_match_b_i);
  assign hit_dma_b = dmac_match_b_i && (!data_en_b || data_match_b_i);
  assign hit_b = hit_cpu_b || hit_dma_b;

  ////////////////////////////////////////////////////////////////////
  // Bus handshakes
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic rd_src;
  logic rd_dst;

  assign wr_go = q.awready && s_axi_awvalid && q.wready && s_axi_wvalid;
  assign rd_go = q.arready && s_axi_arvalid;
  assign wmask = lanes(s_axi_wstrb);
  assign rd_src = rd_go && hit(s_axi_araddr,
                               break_trace_pkg::OFS_SRC_TRACE);
  assign rd_dst = rd_go && hit(s_axi_araddr,
                               break_trace_pkg::OFS_DST_TRACE);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic b_ok;
    logic fire_a;
    logic fire_b;
    logic post;
    logic chan_b;
    logic [31:0] wv;
    b_ok = 1'b0;
    fire_a = 1'b0;
    fire_b = 1'b0;
    post = 1'b0;
    chan_b = 1'b0;
    wv = s_axi_wdata & wmask;
    d = q;
    d.brk_req = 1'b0;
    d.brk_post = 1'b0;
    d.brk_chan_b = 1'b0;

    // AXI write: ready offered once both channels wait
    d.awready = 1'b0;
    d.wready = 1'b0;
    if (!q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = break_trace_pkg::RESP_OKAY;
      if (hit(s_axi_awaddr, break_trace_pkg::OFS_CONTROL)) begin
        // Plain bits take the written value; flags only clear
        d.ctrl = (q.ctrl & ~(wmask & break_trace_pkg::CTRL_RW_MASK))
               | (wv & break_trace_pkg::CTRL_RW_MASK
                  & ~break_trace_pkg::CTRL_FLAG_MASK);
        d.ctrl = d.ctrl | (q.ctrl & break_trace_pkg::CTRL_FLAG_MASK
                 & (s_axi_wdata | ~wmask));
      end else if (hit(s_axi_awaddr, break_trace_pkg::OFS_COUNT)) begin
        d.count = (q.count & ~wmask[11:0]) | wv[11:0];
      end else if (hit(s_axi_awaddr,
                       break_trace_pkg::OFS_SPACE_ID)) begin
        d.space_id = (q.space_id & ~wmask[7:0]) | wv[7:0];
      end else if (hit(s_axi_awaddr, break_trace_pkg::OFS_SRC_TRACE) ||
                   hit(s_axi_awaddr, break_trace_pkg::OFS_DST_TRACE))
      begin
        d.bresp = break_trace_pkg::RESP_OKAY;
      end else begin
        d.bresp = break_trace_pkg::RESP_SLVERR;
      end
    end

    // AXI read: one request at a time
    d.arready = !q.arready && !q.rvalid && s_axi_arvalid;
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = break_trace_pkg::RESP_OKAY;
      d.rdata = '0;
      if (hit(s_axi_araddr, break_trace_pkg::OFS_CONTROL)) begin
        d.rdata = q.ctrl & break_trace_pkg::CTRL_RW_MASK;
      end else if (hit(s_axi_araddr, break_trace_pkg::OFS_COUNT)) begin
        d.rdata = {20'h0_0000, q.count};
      end else if (rd_src) begin
        d.rdata = {q.src_valid[0], q.src_entry[0]};
      end else if (rd_dst) begin
        d.rdata = {q.dst_valid[0], 3'h0, q.dst_addr[0]};
      end else if (hit(s_axi_araddr,
                       break_trace_pkg::OFS_SPACE_ID)) begin
        d.rdata = {24'h00_0000, q.space_id};
      end else begin
        d.rresp = break_trace_pkg::RESP_SLVERR;
      end
    end

    // Reading a queue pops its newest entry, so eight reads drain it
    if (rd_src) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.src_valid[i] = q.src_valid[i+1];
        d.src_entry[i] = q.src_entry[i+1];
      end
      d.src_valid[DEPTH-1] = 1'b0;
    end
    if (rd_dst) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.dst_valid[i] = q.dst_valid[i+1];
        d.dst_addr[i] = q.dst_addr[i+1];
      end
      d.dst_valid[DEPTH-1] = 1'b0;
    end

    // Branch capture wins over a pop; only the popped entry goes invalid
    if (branch_i && trace_en) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        d.src_valid[i] = q.src_valid[i-1] && !(rd_src && i == 1);
        d.src_entry[i] = q.src_entry[i-1];
        d.dst_valid[i] = q.dst_valid[i-1] && !(rd_dst && i == 1);
        d.dst_addr[i] = q.dst_addr[i-1];
      end
      d.src_valid[0] = 1'b1;
      d.src_entry[0] = {decode_buffer_ptr_i, source_addr_i};
      d.dst_valid[0] = 1'b1;
      d.dst_addr[0] = dest_addr_i;
    end
    d.buf_num = buf_of(d.src_entry[0][30:28]);

    // Match flags; a set in the same cycle beats a software clear
    if (hit_cpu_a) begin
      d.ctrl[break_trace_pkg::BIT_FLAG_CPU_A] = 1'b1;
    end
    if (hit_dma_a) begin
      d.ctrl[break_trace_pkg::BIT_FLAG_DMA_A] = 1'b1;
    end
    if (hit_cpu_b) begin
      d.ctrl[break_trace_pkg::BIT_FLAG_CPU_B] = 1'b1;
    end
    if (hit_dma_b) begin
      d.ctrl[break_trace_pkg::BIT_FLAG_DMA_B] = 1'b1;
    end

    // Sequential: B counts only after A, and not in A's cycle
    if (seq_mode) begin
      b_ok = q.seq_armed && hit_b && !hit_a;
      if (hit_a) begin
        d.seq_armed = 1'b1;
      end else if (b_ok) begin
        d.seq_armed = 1'b0;
      end
    end else begin
      b_ok = hit_b;
      fire_a = hit_a;
      d.seq_armed = 1'b0;
    end

    // Execution count: decrement per match, break on the last one
    if (count_en) begin
      if (b_ok) begin
        fire_b = (q.count == break_trace_pkg::COUNT_LAST);
        if (q.count != break_trace_pkg::COUNT_RESET) begin
          d.count = q.count - break_trace_pkg::COUNT_LAST;
        end
      end
    end else begin
      fire_b = b_ok;
    end

    // Fetch breaks wait for execution when the after bit is set
    if (fire_a && fetch_a_i && after_a) begin
      d.pend_a = 1'b1;
      fire_a = 1'b0;
    end
    if (fire_b && fetch_b_i && after_b) begin
      d.pend_b = 1'b1;
      fire_b = 1'b0;
    end
    if (exec_done_i && (q.pend_a || q.pend_b)) begin
      post = 1'b1;
      chan_b = q.pend_b && !q.pend_a;
      d.pend_a = 1'b0;
      d.pend_b = 1'b0;
    end

    // One request even when both channels hit together
    if (fire_a || fire_b || post) begin
      d.brk_req = 1'b1;
      d.brk_post = post && !(fire_a || fire_b);
      d.brk_chan_b = (fire_a || fire_b) ? !fire_a : chan_b;
    end

    // Manual reset clears only the trace valid flags
    if (manual_reset_i) begin
      d.src_valid = '0;
      d.dst_valid = '0;
    end

    // Power-on reset; trace data and space id are kept
    if (rst_i) begin
      d.ctrl = break_trace_pkg::CTRL_RESET;
      d.count = break_trace_pkg::COUNT_RESET;
      d.src_valid = '0;
      d.dst_valid = '0;
      d.seq_armed = 1'b0;
      d.pend_a = 1'b0;
      d.pend_b = 1'b0;
      d.awready = 1'b0;
      d.wready = 1'b0;
      d.bvalid = 1'b0;
      d.bresp = break_trace_pkg::RESP_OKAY;
      d.arready = 1'b0;
      d.rvalid = 1'b0;
      d.rdata = '0;
      d.rresp = break_trace_pkg::RESP_OKAY;
      d.brk_req = 1'b0;
      d.brk_post = 1'b0;
      d.brk_chan_b = 1'b0;
      d.buf_num = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register; reset is folded into the next-state logic
  always_ff @(posedge ref_clk_i) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign break_req_o = q.brk_req;
  assign break_post_o = q.brk_post;
  assign break_chan_b_o = q.brk_chan_b;
  assign source_buffer_num_o = q.buf_num;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

endmodule : break_control_branch_trace

// [break_trace_props.sv]
`timescale 1ns/10ps
module break_trace_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cpu_match_a_i,
  input wire logic dmac_match_a_i,
  input wire logic cpu_match_b_i,
  input wire logic dmac_match_b_i,
  input wire logic data_match_b_i,
  input wire logic [7:0] address_space_id_i,
  input wire logic fetch_a_i,
  input wire logic fetch_b_i,
  input wire logic exec_done_i,
  input wire logic branch_i,
  input wire logic [2:0] decode_buffer_ptr_i,
  input wire logic break_req_o,
  input wire logic break_post_o,
  input wire logic break_chan_b_o,
  input wire logic [3:0] source_buffer_num_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [31:0] ctl_q;
  logic [7:0] sid_q;
  logic [3:0] num_q;
  logic wr_go;
  logic a_ok;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wready;
  assign a_ok = ctl_q[21] || address_space_id_i == sid_q;
  // Shadow copies; full-word writes only, so strobes are not modelled
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) ctl_q <= '0;
    else if (wr_go && s_axi_awaddr == 8'h00) ctl_q <= s_axi_wdata;
    if (wr_go && s_axi_awaddr == 8'h10) sid_q <= s_axi_wdata[7:0];
    if (branch_i) num_q <= {1'b0, decode_buffer_ptr_i} +
                           {2'b00, decode_buffer_ptr_i[0], 1'b0};
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_a_pre;
    cpu_match_a_i && fetch_a_i && a_ok && !ctl_q[3] && !ctl_q[10]
    |=> break_req_o && !break_post_o && !break_chan_b_o;
  endproperty
  a_a_pre: assert property (p_a_pre)
    else $error("channel A early break missing");
  property p_a_post;
    cpu_match_a_i && fetch_a_i && a_ok && ctl_q[10] && !ctl_q[3] &&
    !cpu_match_b_i && !dmac_match_b_i && !exec_done_i |=> !break_req_o;
  endproperty
  a_a_post: assert property (p_a_post)
    else $error("channel A late break fired early");
  property p_b_pre;
    cpu_match_b_i && fetch_b_i && !cpu_match_a_i && !dmac_match_a_i &&
    (ctl_q & 32'h0000_00C9) == '0
    |=> break_req_o && break_chan_b_o && !break_post_o;
  endproperty
  a_b_pre: assert property (p_b_pre)
    else $error("channel B early break missing");
  property p_data_b;
    ctl_q[7] && !ctl_q[3] && cpu_match_b_i && !dmac_match_b_i &&
    !data_match_b_i && !cpu_match_a_i && !dmac_match_a_i &&
    !exec_done_i |=> !break_req_o;
  endproperty
  a_data_b: assert property (p_data_b)
    else $error("break without data match");
  property p_num;
    branch_i && ctl_q[11] |-> ##[1:2] source_buffer_num_o == num_q;
  endproperty
  a_num: assert property (p_num)
    else $error("buffer number decode wrong");
  property p_wr_ans;
    wr_go |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read data late");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("write response repeated");
  // Main scenarios reached
  c_post: cover property (break_req_o && break_post_o);
  c_chan_b: cover property (break_req_o && break_chan_b_o);
  c_trace: cover property (branch_i && ctl_q[11]);
endmodule : break_trace_props

bind break_control_branch_trace break_trace_props u_props (.*);

// [core_stub.sv]
`timescale 1ns/10ps
// Core stand-in: one branch a chosen number of cycles after a request
module core_stub (
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic [3:0] gap_i,
  input wire logic [58:0] ent_i,
  output logic branch_o,
  output logic [58:0] ent_o
);
  logic [4:0] cnt_q = '0;
  logic [58:0] hold_q;
  // Count down from 16 plus gap; branch fires at 16
  always_ff @(posedge ref_clk_i) begin
    if (go_i) begin
      cnt_q <= {1'b1, gap_i};
      hold_q <= ent_i;
    end else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
  end
  assign branch_o = cnt_q == 5'h10;
  // Off-branch the buses are inverted so stale data never matches
  assign ent_o = branch_o ? hold_q : ~hold_q;
endmodule : core_stub

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] CTL = break_trace_pkg::OFS_CONTROL;
  localparam logic [7:0] CNT = break_trace_pkg::OFS_COUNT;
  localparam logic [7:0] SRC = break_trace_pkg::OFS_SRC_TRACE;
  localparam logic [7:0] DST = break_trace_pkg::OFS_DST_TRACE;
  localparam logic [7:0] SID = break_trace_pkg::OFS_SPACE_ID;
  localparam logic [31:0] RW = break_trace_pkg::CTRL_RW_MASK &
                               ~break_trace_pkg::CTRL_FLAG_MASK;
  localparam logic [31:0] MSK = 32'h0020_0000;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic man_rst = 0;
  logic go = 0;
  logic br, brk, post, chb;
  logic [7:0] ev = '0;
  logic [7:0] address_space_id = '0;
  logic [3:0] gap = '0;
  logic [58:0] ent = '0;
  logic [58:0] ent_w, last_e;
  logic [58:0] hist[$];
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [1:0] brk_info;
  int n_fail = 0, n_checks = 0, brk_n = 0, b0 = 0, cyc = 0;
  // Event bits: 0 cpu A, 1 dmac A, 2 cpu B, 3 dmac B, 4 done, 5/6 fetch
  break_control_branch_trace u_dut (.*, .manual_reset_i(man_rst),
    .cpu_match_a_i(ev[0]), .dmac_match_a_i(ev[1]), .cpu_match_b_i(ev[2]),
    .dmac_match_b_i(ev[3]), .exec_done_i(ev[4]), .fetch_a_i(ev[5]),
    .fetch_b_i(ev[6]), .data_match_b_i(ev[7]), .address_space_id_i(address_space_id),
    .branch_i(br), .source_addr_i(ent_w[55:28]),
    .decode_buffer_ptr_i(ent_w[58:56]), .dest_addr_i(ent_w[27:0]),
    .break_req_o(brk), .break_post_o(post), .break_chan_b_o(chb),
    .source_buffer_num_o(), .s_axi_wstrb(4'hF));
  core_stub u_core (.ref_clk_i(ref_clk_i), .go_i(go), .gap_i(gap),
    .ent_i(ent), .branch_o(br), .ent_o(ent_w));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Break counter and watchdog; a hang ends in the normal report
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (brk === 1'b1) begin
      brk_n <= brk_n + 1;
      brk_info <= {post, chb};
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] src_x(input logic [58:0] e);
    return {1'b1, e[58:56], e[55:28]};
  endfunction : src_x
  function automatic logic [31:0] dst_x(input logic [58:0] e);
    return {4'h8, e[27:0]};
  endfunction : dst_x
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic nb(input int n);
    chk(brk_n - b0, n);
    b0 = brk_n;
  endtask : nb
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  task automatic pulse(input logic [7:0] e);
    @(posedge ref_clk_i);
    ev <= e;
    @(posedge ref_clk_i);
    ev <= '0;
    repeat (3) @(posedge ref_clk_i);
  endtask : pulse
  task automatic branch(input logic [3:0] g);
    @(posedge ref_clk_i);
    last_e = 59'({$urandom, $urandom});
    ent <= last_e;
    gap <= g;
    go <= 1;
    @(posedge ref_clk_i);
    go <= 0;
    repeat (g + 3) @(posedge ref_clk_i);
  endtask : branch
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    void'($urandom(48807));
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 0;
    rd(CTL);
    chk(rd_d, 32'h0000_0000);
    rd(CNT);
    chk(rd_d, 32'h0000_0000);
    rd(SRC);
    chk(rd_d[31], 1'b0);
    wr(CTL, 32'hFFFF_FFFF);
    rd(CTL);
    chk(rd_d, RW);
    wr(CNT, 32'hFFFF_FFFF);
    rd(CNT);
    chk(rd_d, 32'h0000_0FFF);
    // Random control and space id values read back
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      wr(SID, d);
      rd(SID);
      chk(rd_d, {24'h00_0000, d[7:0]});
      wr(CTL, d & RW);
      rd(CTL);
      chk(rd_d, d & RW);
    end
    wr(DST, 32'hFFFF_FFFF);
    chk(rsp, break_trace_pkg::RESP_OKAY);
    rd(DST);
    chk(rd_d[31], 1'b0);
    wr(8'h14, 32'h0000_0000);
    chk(rsp, break_trace_pkg::RESP_SLVERR);
    rd(8'h14);
    chk(rsp, break_trace_pkg::RESP_SLVERR);
    done("registers");
    wr(CTL, MSK);
    pulse(8'h08);
    rd(CTL);
    chk(rd_d, MSK | 32'h0000_1000);
    pulse(8'h02);
    rd(CTL);
    chk(rd_d, MSK | 32'h0000_3000);
    wr(CTL, MSK);
    rd(CTL);
    chk(rd_d, MSK);
    b0 = brk_n;
    done("flags");
    // Early and late fetch breaks on both channels
    for (int i = 0; i < 4; i++) begin
      wr(CTL, MSK | (i[0] ? 32'h0000_0440 : 32'h0000_0000));
      pulse(i[1] ? 8'h44 : 8'h21);
      nb(i[0] ? 0 : 1);
      pulse(8'h10);
      chk(brk_n - b0, i[0]);
      chk(brk_info, {i[0], i[1]});
      b0 = brk_n;
    end
    done("timing");
    wr(SID, 32'h0000_005A);
    wr(CTL, 32'h0000_0000);
    address_space_id <= 8'hA5;
    pulse(8'h21);
    nb(0);
    address_space_id <= 8'h5A;
    pulse(8'h21);
    nb(1);
    wr(CTL, MSK | 32'h0000_0080);
    pulse(8'h04);
    nb(0);
    pulse(8'h84);
    nb(1);
    wr(CTL, MSK | 32'h0000_0008);
    pulse(8'h04);
    pulse(8'h05);
    nb(0);
    pulse(8'h01);
    nb(0);
    pulse(8'h04);
    nb(1);
    done("conditions");
    wr(CTL, MSK | 32'h0000_0001);
    wr(CNT, 32'h0000_0003);
    pulse(8'h04);
    rd(CNT);
    chk(rd_d, 32'h0000_0002);
    pulse(8'h04);
    nb(0);
    pulse(8'h04);
    nb(1);
    rd(CNT);
    chk(rd_d, 32'h0000_0000);
    pulse(8'h04);
    nb(0);
    wr(CTL, MSK);
    wr(CNT, 32'h0000_0002);
    pulse(8'h04);
    nb(1);
    done("count");
    wr(CTL, 32'h0000_0000);
    branch(4'h2);
    rd(SRC);
    chk(rd_d[31], 1'b0);
    wr(CTL, 32'h0000_0800);
    for (int i = 0; i < 10; i++) begin
      branch(4'($urandom_range(9, 0)));
      hist.push_front(last_e);
    end
    // Newest first; the two oldest were shifted out
    for (int i = 0; i < 9; i++) begin
      rd(SRC);
      chk(i < 8 ? rd_d : rd_d[31], i < 8 ? src_x(hist[i]) : 0);
      rd(DST);
      chk(i < 8 ? rd_d : rd_d[31], i < 8 ? dst_x(hist[i]) : 0);
    end
    branch(4'h0);
    @(posedge ref_clk_i);
    man_rst <= 1;
    @(posedge ref_clk_i);
    man_rst <= 0;
    rd(SRC);
    chk(rd_d[31], 1'b0);
    rd(DST);
    chk(rd_d[31], 1'b0);
    done("trace");
    close_out();
  end
endmodule : tb_top
